// file: rtl/tew_core.sv
// echo transmission, open-breaker permissive and weak-source trip logic
// assumes pins are asynchronous, voltage samples arrive on this clock
`timescale 1ns/1ps
`default_nettype none
module tew_core #(
    parameter int TICK_LEN = tew_pkg::TICK_CYCLES // cycles per time-base tick
) (
    input wire logic clock, // 200 MHz clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic breaker_a_state, // high when breaker a is open
    input wire logic breaker_b_state, // high when breaker b is open
    input wire logic permissive_in_side_a, // remote permissive, side a
    input wire logic permissive_in_side_b, // remote permissive, side b
    input wire logic general_fault_pickup, // backward or general pickup
    input wire logic forward_pickup, // forward earth-fault pickup
    input wire logic voltage_sensor_fault, // voltage measuring failure
    input wire logic sample_valid, // new voltage samples
    input wire logic signed [tew_pkg::SAMPLE_W-1:0] phase_a_v, // phase a to earth
    input wire logic signed [tew_pkg::SAMPLE_W-1:0] phase_b_v, // phase b to earth
    input wire logic signed [tew_pkg::SAMPLE_W-1:0] phase_c_v, // phase c to earth
    input wire logic signed [tew_pkg::SAMPLE_W-1:0] neutral_v, // measured displacement
    output logic permissive_out, // outgoing permissive
    output logic return_active, // permissive out is an echo
    output logic weak_source_operate, // weak-source trip
    output logic residual_pickup // residual overvoltage picked up
);
    import tew_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] sync1_reg;
    logic [PIN_COUNT-1:0] sync2_reg;
    logic [PIN_COUNT-1:0] sync3_reg;
    logic [PIN_COUNT-1:0] pin_reg;
    logic [PIN_COUNT-1:0] pin_next;

    assign pin_raw = {voltage_sensor_fault, forward_pickup, general_fault_pickup,
        permissive_in_side_b, permissive_in_side_a, breaker_b_state, breaker_a_state};
    // a change is taken only once stages two and three agree
    assign pin_next = (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= pin_next;
        end
    end

    wire a_open = pin_reg[0];
    wire b_open = pin_reg[1];
    wire rx_a = pin_reg[2];
    wire rx_b = pin_reg[3];
    wire gen_pick = pin_reg[4];
    wire fwd_pick = pin_reg[5];
    wire vt_fault = pin_reg[6];

    // ****************************************
    // registers
    // ****************************************
    logic [CTRL_W-1:0] ctrl_reg;
    logic [DELAY_W-1:0] ob_delay_reg;
    logic [DELAY_W-1:0] confirm_reg;
    logic [DELAY_W-1:0] pulse_reg;
    logic [DELAY_W-1:0] repeat_reg;
    logic [DELAY_W-1:0] post_reg;
    logic [DELAY_W-1:0] trip_delay_reg;
    logic [15:0] thresh_reg;
    logic [15:0] rated_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire access = psel && penable && !pready_reg;
    // a write lands only at the edge where the master sees ready
    wire wr = psel && penable && pwrite && pready_reg;
    wire hit_ctrl = paddr == CTRL_OFS;
    wire hit_ob = paddr == OB_DELAY_OFS;
    wire hit_conf = paddr == CONFIRM_OFS;
    wire hit_pulse = paddr == PULSE_OFS;
    wire hit_rep = paddr == REPEAT_OFS;
    wire hit_post = paddr == POST_OFS;
    wire hit_trip = paddr == TRIP_DELAY_OFS;
    wire hit_thr = paddr == THRESH_OFS;
    wire hit_rated = paddr == RATED_OFS;
    wire hit_stat = paddr == STATUS_OFS;
    wire mapped = hit_ctrl || hit_ob || hit_conf || hit_pulse || hit_rep || hit_post ||
        hit_trip || hit_thr || hit_rated || hit_stat;

    wire ob_en = ctrl_reg[CTRL_OB_EN];
    wire echo_en = ctrl_reg[CTRL_ECHO_EN];
    wire trip_en = ctrl_reg[CTRL_TRIP_EN];
    wire overreach = ctrl_reg[CTRL_OVERREACH];
    wire vsup = ctrl_reg[CTRL_VSUP];
    wire b_used = ctrl_reg[CTRL_B_USED];
    wire neutral_sel = ctrl_reg[CTRL_NEUTRAL];

    logic [31:0] status_word;
    logic [31:0] rd_mux;
    tew_echo_state_t state_reg;
    tew_echo_state_t state_next;
    logic ob_tx_reg;
    logic post_run_reg;
    logic pick_reg;
    logic trip_reg;
    logic echo_reg;
    logic perm_reg;

    assign status_word = {24'h000000, state_reg, post_run_reg, trip_reg, perm_reg,
        echo_reg, pick_reg, ob_tx_reg};
    assign rd_mux = hit_ctrl ? {25'h0000000, ctrl_reg} :
        hit_ob ? {16'h0000, ob_delay_reg} :
        hit_conf ? {16'h0000, confirm_reg} :
        hit_pulse ? {16'h0000, pulse_reg} :
        hit_rep ? {16'h0000, repeat_reg} :
        hit_post ? {16'h0000, post_reg} :
        hit_trip ? {16'h0000, trip_delay_reg} :
        hit_thr ? {16'h0000, thresh_reg} :
        hit_rated ? {16'h0000, rated_reg} :
        hit_stat ? status_word : 32'h00000000;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
            ob_delay_reg <= DELAY_RST;
            confirm_reg <= DELAY_RST;
            pulse_reg <= DELAY_RST;
            repeat_reg <= DELAY_RST;
            post_reg <= DELAY_RST;
            trip_delay_reg <= DELAY_RST;
            thresh_reg <= THRESH_RST;
            rated_reg <= RATED_RST;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_reg <= pwdata[CTRL_W-1:0];
            end else if (hit_ob) begin
                ob_delay_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_conf) begin
                confirm_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_pulse) begin
                pulse_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_rep) begin
                repeat_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_post) begin
                post_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_trip) begin
                trip_delay_reg <= pwdata[DELAY_W-1:0];
            end else if (hit_thr) begin
                thresh_reg <= pwdata[15:0];
            end else if (hit_rated) begin
                rated_reg <= pwdata[15:0];
            end
        end
    end

    // answer one cycle into the access phase
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access && !mapped;
            if (access && !pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // ****************************************
    // time base
    // ****************************************
    logic [31:0] presc_reg;
    logic tick_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            presc_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (presc_reg >= 32'(TICK_LEN - 1)) begin
            presc_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end else begin
            presc_reg <= presc_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    // ****************************************
    // residual overvoltage stage
    // ****************************************
    logic signed [RESID_W-1:0] resid;
    logic [RESID_W-1:0] resid_mag;
    logic [31:0] thr_prod;
    logic [RESID_W-1:0] thr_on;
    logic [RESID_W-1:0] thr_off;

    assign resid = neutral_sel ? RESID_W'(neutral_v) :
        RESID_W'(phase_a_v) + RESID_W'(phase_b_v) + RESID_W'(phase_c_v);
    assign resid_mag = resid[RESID_W-1] ? RESID_W'(-resid) : RESID_W'(resid);
    assign thr_prod = thresh_reg * rated_reg;
    assign thr_on = thr_prod[PU_FRAC+RESID_W-1:PU_FRAC];
    assign thr_off = thr_on - (thr_on >> HYST_SHIFT);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pick_reg <= 1'b0;
        end else if (sample_valid) begin
            if (resid_mag > thr_on) begin
                pick_reg <= 1'b1;
            end else if (resid_mag < thr_off) begin
                pick_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // open breaker permissive
    // ****************************************
    // second breaker gates the open state
    wire cb_open = a_open && (!b_used || b_open);
    wire ob_run = ob_en && overreach && cb_open;
    wire ob_done;

    tew_delay_timer u_ob_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(ob_run),
        .limit(ob_delay_reg),
        .expired(ob_done)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ob_tx_reg <= 1'b0;
        end else begin
            ob_tx_reg <= ob_done;
        end
    end

    // ****************************************
    // post-pickup inhibit
    // ****************************************
    logic gen_prev_reg;
    wire post_done;

    tew_delay_timer u_post_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(post_run_reg),
        .limit(post_reg),
        .expired(post_done)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            gen_prev_reg <= 1'b0;
            post_run_reg <= 1'b0;
        end else begin
            gen_prev_reg <= gen_pick;
            if (gen_pick || post_done) begin
                post_run_reg <= 1'b0;
            end else if (gen_prev_reg) begin
                post_run_reg <= 1'b1;
            end
        end
    end

    wire pickup_block = gen_pick || post_run_reg;
    wire rx_any = rx_a || rx_b;

    // ****************************************
    // echo sequencer
    // ****************************************
    // echo qualification
    wire echo_cond = echo_en && overreach && rx_any && !pickup_block && (!vsup || pick_reg);
    wire conf_done;
    wire pulse_done;
    wire rep_done;

    tew_delay_timer u_conf_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(state_reg == TEW_CONFIRM && echo_cond),
        .limit(confirm_reg),
        .expired(conf_done)
    );

    tew_delay_timer u_pulse_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(state_reg == TEW_PULSE),
        .limit(pulse_reg),
        .expired(pulse_done)
    );

    tew_delay_timer u_rep_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(state_reg == TEW_BLOCK),
        .limit(repeat_reg),
        .expired(rep_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TEW_IDLE: begin
                if (echo_cond) begin
                    state_next = cb_open ? TEW_PULSE : TEW_CONFIRM;
                end
            end
            TEW_CONFIRM: begin
                if (!echo_cond) begin
                    state_next = TEW_IDLE;
                end else if (conf_done) begin
                    state_next = TEW_PULSE;
                end
            end
            TEW_PULSE: begin
                if (pulse_done) begin
                    state_next = TEW_BLOCK;
                end
            end
            TEW_BLOCK: begin
                if (rep_done) begin
                    state_next = TEW_IDLE;
                end
            end
            default: begin
                state_next = TEW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= TEW_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // weak-source trip
    // ****************************************
    // trip qualification
    wire trip_cond = trip_en && overreach && rx_any && !fwd_pick && !pickup_block &&
        pick_reg && !vt_fault;
    wire trip_done;

    tew_delay_timer u_trip_timer (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_reg),
        .run(trip_cond),
        .limit(trip_delay_reg),
        .expired(trip_done)
    );

    // ****************************************
    // outputs
    // ****************************************
    // echo on permissive out plus indication
    always_ff @(posedge clock) begin
        if (!nrst) begin
            echo_reg <= 1'b0;
            perm_reg <= 1'b0;
            trip_reg <= 1'b0;
        end else begin
            echo_reg <= state_next == TEW_PULSE;
            perm_reg <= ob_done || state_next == TEW_PULSE;
            trip_reg <= trip_done;
        end
    end

    assign permissive_out = perm_reg;
    assign return_active = echo_reg;
    assign weak_source_operate = trip_reg;
    assign residual_pickup = pick_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

// file: rtl/tew_pkg.sv
// constants shared by the echo, open-breaker and weak-source trip logic
// assumes one 200 MHz clock and an apb master with 32-bit data
package tew_pkg;
    // ****************************************
    // clock and time base
    // ****************************************
    localparam int CLOCK_MHZ = 200;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
    localparam int DELAY_W = 16;
    localparam int SAMPLE_W = 16;
    localparam int RESID_W = 18;
    localparam int PIN_COUNT = 7;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OB_DELAY_OFS = 8'h04;
    localparam logic [7:0] CONFIRM_OFS = 8'h08;
    localparam logic [7:0] PULSE_OFS = 8'h0c;
    localparam logic [7:0] REPEAT_OFS = 8'h10;
    localparam logic [7:0] POST_OFS = 8'h14;
    localparam logic [7:0] TRIP_DELAY_OFS = 8'h18;
    localparam logic [7:0] THRESH_OFS = 8'h1c;
    localparam logic [7:0] RATED_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;

    // ****************************************
    // control fields
    // ****************************************
    localparam int CTRL_OB_EN = 0;
    localparam int CTRL_ECHO_EN = 1;
    localparam int CTRL_TRIP_EN = 2;
    localparam int CTRL_OVERREACH = 3;
    localparam int CTRL_VSUP = 4;
    localparam int CTRL_B_USED = 5;
    localparam int CTRL_NEUTRAL = 6;
    localparam int CTRL_W = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
    localparam logic [15:0] THRESH_RST = 16'h0040;
    localparam logic [15:0] RATED_RST = 16'h4000;
    // pickup drops at threshold minus threshold/2^HYST_SHIFT
    localparam int HYST_SHIFT = 5;
    // per-unit threshold is q8.8
    localparam int PU_FRAC = 8;

    typedef enum logic [1:0] {
        TEW_IDLE,
        TEW_CONFIRM,
        TEW_PULSE,
        TEW_BLOCK
    } tew_echo_state_t;
endpackage

// file: rtl/tew_delay_timer.sv
// one delay timer counting time-base ticks while its start condition holds
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module tew_delay_timer (
    input wire logic clock, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic tick, // time-base pulse
    input wire logic run, // start condition, clears count when low
    input wire logic [15:0] limit, // delay in ticks
    output logic expired // delay elapsed while run held
);
    logic [15:0] count_reg;
    logic [15:0] count_next;

    assign count_next = !run ? 16'h0000 :
        (tick && count_reg < limit) ? count_reg + 16'h0001 : count_reg;
    assign expired = run && (count_reg >= limit);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            count_reg <= 16'h0000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// file: verif/tew_monitor.sv
// checker of the core's port behaviour, bound onto tew_core
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tew_monitor (
    input wire logic clock, // clock
    input wire logic nrst, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic permissive_in_side_a, // rx a
    input wire logic permissive_in_side_b, // rx b
    input wire logic general_fault_pickup, // general pickup
    input wire logic forward_pickup, // forward pickup
    input wire logic voltage_sensor_fault, // vt fault
    input wire logic permissive_out, // tx permissive
    input wire logic return_active, // echo
    input wire logic weak_source_operate // trip
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ****
    // bus and outputs
    // ****
    AST_APB_READY: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held");
    AST_SLVERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_ECHO_IND: assert property (return_active |-> permissive_out)
        else $error("echo not on permissive");
    AST_RESET: assert property (disable iff (1'b0) !nrst |=>
        !permissive_out && !return_active && !weak_source_operate)
        else $error("output after reset");
    // ****
    // blocking relations
    // ****
    AST_TRIP_VT: assert property (voltage_sensor_fault [*8] |-> !weak_source_operate)
        else $error("trip with vt fault");
    AST_TRIP_FWD: assert property (forward_pickup [*8] |-> !weak_source_operate)
        else $error("trip with forward pickup");
    AST_GP_BLOCK: assert property (general_fault_pickup [*8] |-> !$rose(return_active))
        else $error("echo during pickup");
    AST_RX_NEEDED: assert property ((!permissive_in_side_a && !permissive_in_side_b) [*8]
        |-> !$rose(return_active))
        else $error("echo without rx");
    cover property ($rose(return_active));
    cover property ($rose(weak_source_operate));
    cover property ($fell(weak_source_operate));
endmodule
bind tew_core tew_monitor u_mon (.clock, .nrst, .psel, .penable, .pready, .pslverr,
    .permissive_in_side_a, .permissive_in_side_b, .general_fault_pickup, .forward_pickup,
    .voltage_sensor_fault, .permissive_out, .return_active, .weak_source_operate);
`default_nettype wire

// file: verif/tew_remote.sv
// remote line-end relays keying permissive channels on command
// assumes the bench sets the keys after rising edges
`timescale 1ns/1ps
`default_nettype none
module tew_remote (
    input wire logic clock, // clock
    input wire logic key_a, // bench keys remote a
    input wire logic key_b, // bench keys remote b
    input wire logic permissive_out, // permissive from the core
    output logic permissive_in_side_a, // rx a
    output logic permissive_in_side_b, // rx b
    output int echoes // permissive rises seen
);
    logic last = 1'b0;
    initial echoes = 0;
    // levels are held, so no released-line pattern applies
    assign permissive_in_side_a = key_a;
    assign permissive_in_side_b = key_b;
    // plain always: the counters carry initial values of their own
    always @(posedge clock) begin
        last <= permissive_out;
        if (permissive_out && !last) begin
            echoes <= echoes + 1;
        end
    end
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for tew_core over apb
// assumes TICK_LEN of 10 cycles; delays counted in ticks
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tew_pkg::*;
    logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ba = 0, bb = 0, ka = 0, kb = 0, gp = 0, fp = 0, vf = 0;
    logic signed [15:0] ph = 16'sh0, nv = 16'sh0;
    logic pa, pb, pout, ret, trip, rpu;
    int n_errors = 0, checked = 0, n, echoes;
    logic [31:0] q;
    logic e;
    tew_core #(.TICK_LEN(10)) uut (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .breaker_a_state(ba), .breaker_b_state(bb),
        .permissive_in_side_a(pa), .permissive_in_side_b(pb), .general_fault_pickup(gp),
        .forward_pickup(fp), .voltage_sensor_fault(vf), .sample_valid(1'b1),
        .phase_a_v(ph), .phase_b_v(ph), .phase_c_v(ph), .neutral_v(nv),
        .permissive_out(pout), .return_active(ret), .weak_source_operate(trip),
        .residual_pickup(rpu));
    tew_remote u_rem (.clock(clock), .key_a(ka), .key_b(kb), .permissive_out(pout),
        .permissive_in_side_a(pa), .permissive_in_side_b(pb), .echoes(echoes));
    initial forever #2.5 clock = ~clock;
    // ****
    // helpers
    // ****
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            n_errors++;
            $display("Error %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return ret;
            1: return trip;
            2: return rpu;
            default: return pout;
        endcase
    endfunction
    // bounded wait for a level; running out ends the run
    task automatic wt(input int s, input logic v, output int c);
        c = 0;
        while (sig(s) !== v && c < 400) begin
            @(posedge clock);
            c++;
        end
        if (c >= 400) begin
            chk(32'h0, 32'h1);
            conclude();
        end
    endtask
    task automatic hold(input int s, input logic v, input int c);
        repeat (c) begin
            @(posedge clock);
            if (sig(s) !== v) chk({31'h0, sig(s)}, {31'h0, v});
        end
        checked++;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            chk(32'h0, 32'h1);
            conclude();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk({29'h0, pout, ret, trip}, 32'h0);
        rd(THRESH_OFS, 32'h40);
        rd(RATED_OFS, 32'h4000);
        rd(CTRL_OFS, 32'h0);
        rd(8'h28, 32'h0);
        chk({31'h0, e}, 32'h1);
        xfer(1'b1, CONFIRM_OFS, 32'h4);
        rd(CONFIRM_OFS, 32'h4);
        xfer(1'b1, OB_DELAY_OFS, 32'h3);
        xfer(1'b1, PULSE_OFS, 32'h3);
        xfer(1'b1, REPEAT_OFS, 32'h5);
        xfer(1'b1, POST_OFS, 32'h4);
        xfer(1'b1, TRIP_DELAY_OFS, 32'h2);
        // without the overreach scheme nothing is sent
        xfer(1'b1, CTRL_OFS, 32'h07);
        ka <= 1'b1;
        ba <= 1'b1;
        hold(3, 1'b0, 150);
        ka <= 1'b0;
        ba <= 1'b0;
        // let the released pins pass the synchroniser before the scheme is selected
        repeat (6) @(posedge clock);
        xfer(1'b1, CTRL_OFS, 32'h0f);
        ka <= 1'b1;
        wt(0, 1'b1, n);
        rng(n, 30, 50);
        chk({31'h0, pout}, 32'h1);
        wt(0, 1'b0, n);
        rng(n, 20, 32);
        wt(0, 1'b1, n);
        rng(n, 70, 92);
        wt(0, 1'b0, n);
        chk(32'(echoes), 32'h2);
        ka <= 1'b0;
        repeat (60) @(posedge clock);
        ka <= 1'b1;
        repeat (15) @(posedge clock);
        gp <= 1'b1;
        hold(0, 1'b0, 100);
        gp <= 1'b0;
        wt(0, 1'b1, n);
        rng(n, 60, 95);
        wt(0, 1'b0, n);
        ka <= 1'b0;
        ba <= 1'b1;
        wt(3, 1'b1, n);
        rng(n, 20, 40);
        hold(3, 1'b1, 60);
        kb <= 1'b1;
        wt(0, 1'b1, n);
        rng(n, 3, 12);
        wt(0, 1'b0, n);
        kb <= 1'b0;
        xfer(1'b1, CTRL_OFS, 32'h2f);
        wt(3, 1'b0, n);
        rng(n, 0, 12);
        bb <= 1'b1;
        wt(3, 1'b1, n);
        rng(n, 20, 40);
        ba <= 1'b0;
        bb <= 1'b0;
        // voltage supervised echo and weak-source trip
        xfer(1'b1, CTRL_OFS, 32'h1f);
        ka <= 1'b1;
        hold(0, 1'b0, 120);
        ph <= 16'sd2000;
        wt(2, 1'b1, n);
        rng(n, 1, 6);
        wt(1, 1'b1, n);
        rng(n, 8, 24);
        vf <= 1'b1;
        wt(1, 1'b0, n);
        rng(n, 1, 8);
        hold(1, 1'b0, 10);
        vf <= 1'b0;
        wt(1, 1'b1, n);
        fp <= 1'b1;
        wt(1, 1'b0, n);
        rng(n, 1, 8);
        hold(1, 1'b0, 10);
        fp <= 1'b0;
        // residual between drop and pickup levels: only hysteresis keeps it
        ph <= 16'sd1350;
        hold(2, 1'b1, 20);
        ph <= 16'sd1300;
        wt(2, 1'b0, n);
        rng(n, 1, 6);
        xfer(1'b1, CTRL_OFS, 32'h4f);
        ph <= 16'sd2000;
        hold(2, 1'b0, 20);
        nv <= 16'sd5000;
        wt(2, 1'b1, n);
        rng(n, 1, 6);
        ka <= 1'b0;
        conclude();
    end
endmodule
`default_nettype wire
